// File: hw/aper_pkg.sv
// Package with register map, field layout and reset values for event routing
package aper_pkg;
   // ==========================================================
   // Register index (printed values are word indices, not byte offsets)
   localparam int unsigned  IDX_CLEAR      = 32'h0000_0032;
   localparam int unsigned  IDX_ROUTE      = 32'h0000_0034;
   localparam int unsigned  IDX_IRQ_EN     = 32'h0000_0036;
   localparam int unsigned  IDX_STATUS     = 32'h0000_0030;
   localparam int unsigned  IDX_INT_STATUS = 32'h0000_0040;
   localparam int unsigned  IDX_INT_MASK   = 32'h0000_0041;
   // ==========================================================
   // Byte addresses
   localparam logic [11:0] ADDR_CLEAR      = 12'(IDX_CLEAR * 4);
   localparam logic [11:0] ADDR_ROUTE      = 12'(IDX_ROUTE * 4);
   localparam logic [11:0] ADDR_IRQ_EN     = 12'(IDX_IRQ_EN * 4);
   localparam logic [11:0] ADDR_STATUS     = 12'(IDX_STATUS * 4);
   localparam logic [11:0] ADDR_INT_STATUS = 12'(IDX_INT_STATUS * 4);
   localparam logic [11:0] ADDR_INT_MASK   = 12'(IDX_INT_MASK * 4);
   // ==========================================================
   // Field layout: block n group at 4*(n-1)
   localparam int unsigned  NUM_BLK       = 4;
   localparam int unsigned  GRP_STRIDE    = 4;
   localparam int unsigned  POS_HIGH      = 0;
   localparam int unsigned  POS_LOW       = 1;
   localparam int unsigned  POS_ZERO      = 2;
   localparam logic [15:0]  FLAG_MASK     = 16'h7777;
   localparam logic [15:0]  ROUTE_RESET   = 16'h0000;
   localparam logic [15:0]  IRQ_EN_RESET  = 16'h0000;
   // Bit positions of the local interrupt status register
   localparam int unsigned  IST_PWM_EVT   = 0;
   localparam int unsigned  IST_FLAG_IRQ  = 1;
   localparam logic [1:0]   INT_MASK_RESET = 2'h0;
endpackage : aper_pkg

// File: hw/aper_flag_cell.sv
// One status flag with set-over-clear and rising-edge routing
`timescale 1ns/1ns
module aper_flag_cell (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // Set and clear
   input  wire logic set_req,
   input  wire logic clr_req,
   // Enables
   input  wire logic route_en,
   input  wire logic irq_en,
   // Results
   output logic      flag,
   output logic      route_rise,
   output logic      irq_rise
);
   logic next_flag;
   logic rise;

   always_comb begin
      next_flag = flag;
      if (clr_req) begin
         next_flag = 1'b0;
      end
      if (set_req) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end

   assign rise       = next_flag & ~flag;
   assign route_rise = rise & route_en;
   assign irq_rise   = rise & irq_en;
endmodule : aper_flag_cell

// File: hw/aper_event_route.sv
// Event flag clearing and routing for four post-processing blocks
//
// Summary of operation
// - Writing one to zero-crossing clear bit clears it; clear bits read zero.
// - Trip-low clear bits: block 2 bit 5, block 1 bit 1.
// - Trip-high clear bits: block 2 bit 4, block 1 bit 0.
// - Hardware set beats software clear in the same cycle.
// - Route enable groups at bits 0,4,8,12; bits 3,7,11,15 read zero.
// - Enabled zero-crossing flag rising asserts the PWM event.
// - Enabled trip flag rising asserts the PWM event.
// - A flag that stays set raises no further PWM events.
// - Interrupt-enabled flag rising asserts flag_irq.
// - A flag still set gives no further interrupt until cleared.
// - Interrupt enable uses same layout; block 4 at bits 14..12.
// - Route enable resets to zero.
// - Interrupt enable resets to zero.
// - Flags set regardless of interrupt enable.
// - Zero-crossing flag sets on sign change qualified by end of conversion.
`timescale 1ns/1ns
module aper_event_route #(
   parameter int unsigned NUM_BLK = aper_pkg::NUM_BLK
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_b,
   // AHB-Lite slave
   input  wire logic               hsel,
   input  wire logic [11:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   // Post-processing block conditions
   input  wire logic [NUM_BLK-1:0] blk_eoc,
   input  wire logic [NUM_BLK-1:0] blk_result_sign,
   input  wire logic [NUM_BLK-1:0] blk_high_limit,
   input  wire logic [NUM_BLK-1:0] blk_low_limit,
   // Event outputs
   output logic                    pwm_event,
   output logic                    flag_irq,
   output logic                    irq
);
   // Flag vectors are laid out for exactly four blocks
   if (NUM_BLK != aper_pkg::NUM_BLK) begin : g_bad_blk
      $error("aper_event_route supports four blocks only");
   end

   localparam int unsigned NF = 16;

   // ==========================================================
   // Bus address phase capture
   logic        ph_valid;
   logic        ph_write;
   logic [11:0] ph_addr;
   logic        take;

   assign take = hsel & hready & htrans[1];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= 12'h000;
      end else if (hready) begin
         ph_valid <= take;
         ph_write <= hwrite;
         ph_addr  <= {haddr[11:2], 2'b00};
      end
   end

   logic wr_clear;
   logic wr_route;
   logic wr_irq_en;
   logic wr_mask;
   logic rd_int_status;
   assign wr_clear  = ph_valid & ph_write & (ph_addr == aper_pkg::ADDR_CLEAR);
   assign wr_route  = ph_valid & ph_write & (ph_addr == aper_pkg::ADDR_ROUTE);
   assign wr_irq_en = ph_valid & ph_write
                      & (ph_addr == aper_pkg::ADDR_IRQ_EN);
   assign wr_mask   = ph_valid & ph_write
                      & (ph_addr == aper_pkg::ADDR_INT_MASK);
   // Cleared at the edge that captures the read data, so an event
   // landing in the address cycle survives for the next read
   assign rd_int_status = take & ~hwrite
      & ({haddr[11:2], 2'b00} == aper_pkg::ADDR_INT_STATUS);

   // ==========================================================
   // Enable registers
   logic [15:0] route_en;
   logic [15:0] irq_en;
   logic [1:0]  int_mask;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         route_en <= aper_pkg::ROUTE_RESET;
      end else if (wr_route) begin
         route_en <= hwdata[15:0] & aper_pkg::FLAG_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_en <= aper_pkg::IRQ_EN_RESET;
      end else if (wr_irq_en) begin
         irq_en <= hwdata[15:0] & aper_pkg::FLAG_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_mask <= aper_pkg::INT_MASK_RESET;
      end else if (wr_mask) begin
         int_mask <= hwdata[1:0];
      end
   end

   // ==========================================================
   // Condition sampling: zero crossing on sign change at end of conversion
   logic [NUM_BLK-1:0] last_sign;
   logic [15:0]        set_vec;
   logic [15:0]        clr_vec;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         last_sign <= '0;
      end else begin
         for (int b = 0; b < NUM_BLK; b++) begin
            if (blk_eoc[b]) begin
               last_sign[b] <= blk_result_sign[b];
            end
         end
      end
   end

   always_comb begin
      set_vec = 16'h0000;
      for (int b = 0; b < NUM_BLK; b++) begin
         set_vec[b*4 + aper_pkg::POS_HIGH] = blk_high_limit[b];
         set_vec[b*4 + aper_pkg::POS_LOW]  = blk_low_limit[b];
         set_vec[b*4 + aper_pkg::POS_ZERO] = blk_eoc[b]
            & (blk_result_sign[b] ^ last_sign[b]);
      end
   end

   // Clear bits are pulses only, never stored
   assign clr_vec = wr_clear ? (hwdata[15:0] & aper_pkg::FLAG_MASK)
                             : 16'h0000;

   // ==========================================================
   // Flag cells
   logic [15:0] flags;
   logic [15:0] route_rise;
   logic [15:0] irq_rise;

   genvar g;
   generate
      for (g = 0; g < NF; g++) begin : g_cell
         if (aper_pkg::FLAG_MASK[g]) begin : g_used
            aper_flag_cell u_cell (
               .core_clk   (core_clk),
               .rst_b      (rst_b),
               .set_req    (set_vec[g]),
               .clr_req    (clr_vec[g]),
               .route_en   (route_en[g]),
               .irq_en     (irq_en[g]),
               .flag       (flags[g]),
               .route_rise (route_rise[g]),
               .irq_rise   (irq_rise[g])
            );
         end else begin : g_rsvd
            assign flags[g]      = 1'b0;
            assign route_rise[g] = 1'b0;
            assign irq_rise[g]   = 1'b0;
         end
      end
   endgenerate

   // ==========================================================
   // Outputs: one-cycle pulses only on a rising flag
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_event <= 1'b0;
         flag_irq  <= 1'b0;
      end else begin
         pwm_event <= |route_rise;
         flag_irq  <= |irq_rise;
      end
   end

   // ==========================================================
   // Local interrupt status, cleared on read, set wins
   logic [1:0] int_status;
   logic [1:0] int_set;
   assign int_set = {|irq_rise, |route_rise};

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_status <= 2'b00;
      end else begin
         int_status <= (rd_int_status ? 2'b00 : int_status) | int_set;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status & int_mask);
      end
   end

   // ==========================================================
   // Read data and response: zero wait states, always OKAY
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (take && !hwrite) begin
         case ({haddr[11:2], 2'b00})
            aper_pkg::ADDR_STATUS:     next_rdata = {16'h0000, flags};
            aper_pkg::ADDR_ROUTE:      next_rdata = {16'h0000, route_en};
            aper_pkg::ADDR_IRQ_EN:     next_rdata = {16'h0000, irq_en};
            aper_pkg::ADDR_INT_STATUS: next_rdata = {30'h0, int_status};
            aper_pkg::ADDR_INT_MASK:   next_rdata = {30'h0, int_mask};
            default:                   next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h0000_0000;
      end else if (hready) begin
         hrdata <= next_rdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions
   // Clear pulses: a lone clear empties its flag at the next edge
   a_clear_takes: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (clr_vec[2] && !set_vec[2]) |=> !flags[2])
      else $error("zero-cross clear did not clear flag");

   a_low_clear: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (clr_vec[5] && !set_vec[5]) |=> !flags[5])
      else $error("trip-low clear failed");

   a_low_clear_b1: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (clr_vec[1] && !set_vec[1]) |=> !flags[1])
      else $error("block 1 trip-low clear failed");

   a_high_clear: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (clr_vec[0] && !set_vec[0]) |=> !flags[0])
      else $error("trip-high clear failed");

   a_high_clear_b2: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (clr_vec[4] && !set_vec[4]) |=> !flags[4])
      else $error("block 2 trip-high clear failed");

   a_set_wins: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (set_vec != 16'h0000 && clr_vec != 16'h0000)
      |=> ((flags & $past(set_vec & aper_pkg::FLAG_MASK))
           == $past(set_vec & aper_pkg::FLAG_MASK)))
      else $error("clear won over set");

   a_rsvd_zero: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      ((route_en | irq_en | flags) & ~aper_pkg::FLAG_MASK) == 16'h0000)
      else $error("reserved bit set");

   // Conditions set flags whatever the enables hold
   a_high_sets: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      blk_high_limit[0] |=> flags[0])
      else $error("trip-high condition did not set flag");

   a_high_sets_b4: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      blk_high_limit[3] |=> flags[12])
      else $error("block 4 trip-high condition did not set flag");

   a_zero_gated: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      $rose(flags[2]) |-> $past(blk_eoc[0]))
      else $error("zero-cross flag set without conversion end");

   a_zero_gated_b4: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      $rose(flags[14]) |-> $past(blk_eoc[3]))
      else $error("block 4 zero-cross flag set without conversion end");

   // Routing: one pulse per enabled rise, none while a flag stays set
   a_event_rise: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      ($rose(flags[2]) && route_en[2] && !$past(wr_route)) |-> pwm_event)
      else $error("zero-cross event missing");

   a_trip_event: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (route_rise[1] || route_rise[8]) |=> pwm_event)
      else $error("trip event missing");

   sequence s_held;
      flags[0] [*2];
   endsequence

   sequence s_others_still;
      flags[15:1] == $past(flags[15:1]);
   endsequence

   a_no_repeat: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (s_held ##0 s_others_still) |-> !pwm_event)
      else $error("repeat event on held flag");

   a_rise_only: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      pwm_event |-> ((flags & ~$past(flags) & $past(route_en)) != 16'h0000))
      else $error("event without an enabled rising flag");

   a_irq_rise: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      ($rose(flags[13]) && irq_en[13] && !$past(wr_irq_en)) |-> flag_irq)
      else $error("interrupt missing on rising flag");

   a_trip_irq: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (irq_rise[5] || irq_rise[12]) |=> flag_irq)
      else $error("trip interrupt missing");

   a_irq_quiet: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (irq_rise == 16'h0000) |=> !flag_irq)
      else $error("interrupt without rising flag");

   a_irq_once: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      flag_irq |-> ((flags & ~$past(flags) & $past(irq_en)) != 16'h0000))
      else $error("interrupt without an enabled rising flag");
endmodule : aper_event_route

// File: dv/aper_far_end.sv
// Far-end model: counts PWM events and interrupts it receives
`timescale 1ns/1ns
module aper_far_end (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // Event inputs
   input  wire logic        pwm_event,
   input  wire logic        flag_irq,
   // Delivered counts
   output logic      [15:0] pwm_cnt,
   output logic      [15:0] irq_cnt
);
   // =========================================================
   // Counting
   // Every high cycle is one delivered pulse, so a repeat shows
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_cnt <= 16'h0000;
         irq_cnt <= 16'h0000;
      end else begin
         // An unknown pulse poisons the count, so the bench sees it
         pwm_cnt <= pwm_cnt + {15'h0000, pwm_event};
         irq_cnt <= irq_cnt + {15'h0000, flag_irq};
      end
   end
endmodule : aper_far_end

// File: dv/aper_event_route_test.sv
// Self-checking bench for the event flag routing block
`timescale 1ns/1ns
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin \
   err_total++; $display("FAIL t=%0t got=%h exp=%h", $time, act, exp); end end
module aper_event_route_test;
   // =========================================================
   // Signals
   logic        core_clk = 1'b0;
   logic        rst_b    = 1'b0;
   logic        hsel     = 1'b0;
   logic [11:0] haddr    = 12'h000;
   logic [1:0]  htrans   = 2'h0;
   logic        hwrite   = 1'b0;
   logic [2:0]  hsize    = 3'h2;
   logic [31:0] hwdata   = 32'h0000_0000;
   logic [31:0] hrdata, e, r;
   logic        hreadyout, hresp, pwm_event, flag_irq, irq;
   logic [3:0]  eoc = 4'h0, sgn = 4'h0, hi = 4'h0, lo = 4'h0;
   logic        rd_ph = 1'b0;
   logic [31:0] exp_q[$];
   int          err_total = 0, n_tests = 0, seed = 23;
   logic [15:0] pwm_cnt, irq_cnt;
   int          npwm = 0, nirq = 0;

   always #4 core_clk = ~core_clk;

   aper_event_route i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .blk_eoc(eoc), .blk_result_sign(sgn),
      .blk_high_limit(hi), .blk_low_limit(lo), .pwm_event(pwm_event),
      .flag_irq(flag_irq), .irq(irq));

   aper_far_end i_far (
      .core_clk(core_clk), .rst_b(rst_b), .pwm_event(pwm_event),
      .flag_irq(flag_irq), .pwm_cnt(pwm_cnt), .irq_cnt(irq_cnt));

   // =========================================================
   // Bus master; shi raises trip-high conditions in the data phase
   task automatic bus(input logic [11:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] shi);
      if (!w) exp_q.push_back(d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0000_0000;
      if (shi != 4'h0) hi <= shi;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      if (shi != 4'h0) hi <= 4'h0;
   endtask : bus

   // Read results taken at the edge that ends the data phase
   always @(posedge core_clk) begin
      if (rd_ph && hreadyout === 1'b1) begin
         e = exp_q.pop_front();
         `CHK(hrdata, e)
         `CHK(hresp, 1'b0)
      end
      if (hreadyout === 1'b1) rd_ph <= hsel & htrans[1] & ~hwrite;
   end

   // Raise the condition of status bit f for one cycle
   task automatic hit(input int f);
      int b;
      b = f / 4;
      case (f % 4)
         0: hi[b] <= 1'b1;
         1: lo[b] <= 1'b1;
         default: begin
            sgn[b] <= ~sgn[b];
            eoc[b] <= 1'b1;
         end
      endcase
      @(posedge core_clk);
      hi  <= 4'h0;
      lo  <= 4'h0;
      eoc <= 4'h0;
      repeat (3) @(posedge core_clk);
   endtask : hit

   task automatic cnt(input int dp, input int di);
      npwm += dp;
      nirq += di;
      `CHK(pwm_cnt, npwm)
      `CHK(irq_cnt, nirq)
   endtask : cnt

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test

   // =========================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      bus(12'h0D0, 1'b0, 32'h0000_0000, 4'h0);
      bus(12'h0D8, 1'b0, 32'h0000_0000, 4'h0);
      bus(12'h0C8, 1'b0, 32'h0000_0000, 4'h0);
      bus(12'h0F0, 1'b0, 32'h0000_0000, 4'h0);
      repeat (4) begin
         r = $random(seed);
         bus(12'h0D0, 1'b1, r, 4'h0);
         bus(12'h0D0, 1'b0, r & 32'h0000_7777, 4'h0);
         bus(12'h0D8, 1'b1, ~r, 4'h0);
         bus(12'h0D8, 1'b0, ~r & 32'h0000_7777, 4'h0);
      end
      bus(12'h0D0, 1'b1, 32'h0000_0000, 4'h0);
      bus(12'h0D8, 1'b1, 32'h0000_0000, 4'h0);
      // Settle the sign history, then change sign without a conversion
      eoc <= 4'hF;
      @(posedge core_clk);
      eoc <= 4'h0;
      sgn <= 4'hF;
      bus(12'h0C8, 1'b1, 32'h0000_7777, 4'h0);
      bus(12'h0C0, 1'b0, 32'h0000_0000, 4'h0);
      eoc <= 4'hF;
      hi  <= 4'hF;
      lo  <= 4'hF;
      @(posedge core_clk);
      eoc <= 4'h0;
      hi  <= 4'h0;
      lo  <= 4'h0;
      bus(12'h0C0, 1'b0, 32'h0000_7777, 4'h0);
      cnt(0, 0);
      bus(12'h0C8, 1'b1, 32'h0000_0004, 4'h0);
      bus(12'h0C0, 1'b0, 32'h0000_7773, 4'h0);
      bus(12'h0C8, 1'b1, 32'h0000_0030, 4'h0);
      bus(12'h0C0, 1'b0, 32'h0000_7743, 4'h0);
      bus(12'h0C8, 1'b1, 32'h0000_0003, 4'h0);
      bus(12'h0C0, 1'b0, 32'h0000_7740, 4'h0);
      bus(12'h0C8, 1'b1, 32'h0000_7740, 4'h0);
      bus(12'h0D0, 1'b1, 32'h0000_7777, 4'h0);
      bus(12'h0D8, 1'b1, 32'h0000_7777, 4'h0);
      for (int f = 0; f < 15; f++) if (f % 4 != 3) begin
         hit(f);
         cnt(1, 1);
         hit(f);
         cnt(0, 0);
         bus(12'h0C8, 1'b1, 32'h0000_0001 << f, 4'h0);
         hit(f);
         cnt(1, 1);
         bus(12'h0C8, 1'b1, 32'h0000_0001 << f, 4'h0);
         bus(12'h0C0, 1'b0, 32'h0000_0000, 4'h0);
      end
      // Routing by enable: event path for block 1, interrupt for block 4
      bus(12'h0D0, 1'b1, 32'h0000_0007, 4'h0);
      bus(12'h0D8, 1'b1, 32'h0000_7000, 4'h0);
      hit(0);
      cnt(1, 0);
      hit(14);
      cnt(0, 1);
      bus(12'h0C8, 1'b1, 32'h0000_4001, 4'h0);
      bus(12'h0C8, 1'b1, 32'h0000_0001, 4'h1);
      bus(12'h0C0, 1'b0, 32'h0000_0001, 4'h0);
      cnt(1, 0);
      // Sticky status, mask and level output
      `CHK(irq, 1'b0)
      bus(12'h104, 1'b1, 32'h0000_0003, 4'h0);
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'b1)
      bus(12'h100, 1'b0, 32'h0000_0003, 4'h0);
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'b0)
      bus(12'h100, 1'b0, 32'h0000_0000, 4'h0);
      repeat (2) @(posedge core_clk);
      end_of_test();
   end

   // Run needs under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      end_of_test();
   end
endmodule : aper_event_route_test
